// *** core/otp_pkg.sv ***
`default_nettype none

package otp_pkg;

	// ==========================================================
	// Memory geometry.
	localparam int OTP_CODE_AW    = 14;
	localparam int OTP_CODE_DEPTH = 16384;
	localparam int OTP_KEY_AW     = 6;
	localparam int OTP_KEY_DEPTH  = 64;
	localparam logic [13:0] OTP_SIG_ADDR0 = 14'h0030;
	localparam logic [13:0] OTP_SIG_ADDR1 = 14'h0031;

	// ==========================================================
	// Mode select codes on {mode_sel_a, mode_sel_b, mode_sel_c, mode_sel_d}.
	localparam logic [3:0] OTP_SEL_SIG       = 4'h0;
	localparam logic [3:0] OTP_SEL_VERIFY    = 4'h3;
	localparam logic [3:0] OTP_SEL_PROG_CODE = 4'hB;
	localparam logic [3:0] OTP_SEL_PROG_KEY  = 4'hA;
	localparam logic [3:0] OTP_SEL_LOCK1     = 4'hF;
	localparam logic [3:0] OTP_SEL_LOCK2     = 4'hC;
	localparam logic [3:0] OTP_SEL_LOCK3     = 4'h5;

	// ==========================================================
	// Program strobe timing at the 125 MHz core clock.
	localparam int OTP_CLK_MHZ        = 125;
	localparam int OTP_LOW_NOM_US     = 100;
	localparam int OTP_LOW_TOL_US     = 10;
	localparam int OTP_GAP_MIN_US     = 10;
	localparam int OTP_LOW_MIN_CYC    = (OTP_LOW_NOM_US - OTP_LOW_TOL_US)
		* OTP_CLK_MHZ;
	localparam int OTP_LOW_MAX_CYC    = (OTP_LOW_NOM_US + OTP_LOW_TOL_US)
		* OTP_CLK_MHZ;
	localparam int OTP_GAP_MIN_CYC    = OTP_GAP_MIN_US * OTP_CLK_MHZ;
	localparam int OTP_PULSES         = 5;
	localparam int OTP_CNT_W          = 16;

	// ==========================================================
	// Register map and fields.
	localparam logic [3:0]  OTP_REG_CTRL   = 4'h0;
	localparam logic [3:0]  OTP_REG_STATUS = 4'h4;
	localparam logic [3:0]  OTP_REG_COUNT  = 4'h8;
	localparam int          OTP_CTRL_EN_BIT  = 0;
	localparam logic [31:0] OTP_CTRL_RESET   = 32'h0000_0001;
	localparam int          OTP_STAT_ERR_BIT = 4;
	localparam logic [1:0]  OTP_HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0]  OTP_HSIZE_WORD    = 3'h2;

	typedef enum logic [1:0] {
		OTP_ST_WAIT = 2'b00,
		OTP_ST_LOW  = 2'b01,
		OTP_ST_HIGH = 2'b10
	} otp_pstate_t;

endpackage

`default_nettype wire

// *** core/otp_prog_verify.sv ***
// Decided for this implementation: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Address on ports 1/2, data port 0.
// - Key table loaded with five pulses per address.
// - Verify returns code XNOR key byte.
// - Key table is never readable.
// - Any lock bit blocks code and key writes.
// - Verify drives addressed byte unless locks 2/3.
// - Identification bytes at 030H and 031H.
// - Lock one: block code reads, latch access pin.
// - Locks one and two: verify refused.
// - All locks: external execution refused.
// - Key table starts all ones.
// - Read modes decoded from strobes and selects.
// - Program modes need programming voltage and selects.
// - Lock bits chosen by select pattern.
// - Non-progressive lock patterns act as their highest lock bit.
module otp_prog_verify
#(
	parameter int         LOW_MIN_CYC = otp_pkg::OTP_LOW_MIN_CYC,
	parameter int         LOW_MAX_CYC = otp_pkg::OTP_LOW_MAX_CYC,
	// Identification values are arbitrary.
	parameter logic [7:0] SIG_BYTE0   = 8'hA5,
	parameter logic [7:0] SIG_BYTE1   = 8'h5A
) (
	input  wire logic        i_clock,
	input  wire logic        i_rst_n,
	input  wire logic        i_clk_en,
	input  wire logic        i_prog_reset,
	input  wire logic        i_code_fetch_strobe_n,
	input  wire logic        i_program_strobe_n,
	input  wire logic        i_ext_access_level,
	input  wire logic        i_ext_access_prog_voltage,
	input  wire logic        i_mode_sel_a,
	input  wire logic        i_mode_sel_b,
	input  wire logic        i_mode_sel_c,
	input  wire logic        i_mode_sel_d,
	input  wire logic [7:0]  i_addr_low,
	input  wire logic [5:0]  i_addr_high,
	input  wire logic [7:0]  i_port0_in,
	output logic      [7:0]  o_port0_out,
	output logic      [7:0]  o_port0_oe,
	output logic             o_block_ext_code_read,
	output logic             o_block_ext_exec,
	output logic             o_ext_access_eff,
	input  wire logic        i_hsel,
	input  wire logic [31:0] i_haddr,
	input  wire logic [1:0]  i_htrans,
	input  wire logic        i_hwrite,
	input  wire logic [2:0]  i_hsize,
	input  wire logic [31:0] i_hwdata,
	input  wire logic        i_hready,
	output logic      [31:0] o_hrdata,
	output logic             o_hreadyout,
	output logic             o_hresp
);
	import otp_pkg::*;
	default clocking @(posedge i_clock);
	endclocking
	default disable iff (!i_rst_n);

	// ==========================================================
	// Nonvolatile storage; the arrays and lock bits ignore reset.
	logic [7:0] code_mem [OTP_CODE_DEPTH] = '{default: 8'hFF};
	logic [7:0] key_mem  [OTP_KEY_DEPTH]  = '{default: 8'hFF};
	logic       lock1_reg = 1'b0;
	logic       lock2_reg = 1'b0;
	logic       lock3_reg = 1'b0;

	// ==========================================================
	// Protection levels and mode decode.
	logic [13:0] addr;
	logic [3:0]  sel;
	logic        lvl1;
	logic        lvl2;
	logic        lvl3;
	logic        base_mode;
	logic        read_mode;
	logic        verify_mode;
	logic        sig_mode;
	logic        prog_mode;
	logic        ctrl_en;

	assign addr = {i_addr_high, i_addr_low};
	assign sel  = {i_mode_sel_a, i_mode_sel_b, i_mode_sel_c, i_mode_sel_d};
	// Non-progressive patterns are folded onto the highest set bit.
	assign lvl1 = lock1_reg | lock2_reg | lock3_reg;
	assign lvl2 = lock2_reg | lock3_reg;
	assign lvl3 = lock3_reg;
	assign base_mode = i_prog_reset & ~i_code_fetch_strobe_n;
	assign read_mode = base_mode & i_program_strobe_n & i_ext_access_level
		& ~i_ext_access_prog_voltage;
	assign verify_mode = read_mode & (sel == OTP_SEL_VERIFY);
	assign sig_mode    = read_mode & (sel == OTP_SEL_SIG);
	assign prog_mode   = base_mode & i_ext_access_prog_voltage
		& ctrl_en;

	// ==========================================================
	// Program strobe pulse checker.
	otp_pstate_t          pst_reg;
	logic [OTP_CNT_W-1:0] cnt_reg;
	logic [2:0]           pulses_reg;
	logic                 low_ok;
	logic                 gap_ok;
	logic                 pulse_done;
	logic                 pulse_bad;
	logic                 commit;

	assign low_ok = (cnt_reg >= OTP_CNT_W'(LOW_MIN_CYC))
		&& (cnt_reg <= OTP_CNT_W'(LOW_MAX_CYC));
	assign gap_ok = cnt_reg >= OTP_CNT_W'(OTP_GAP_MIN_CYC);
	assign pulse_done = prog_mode && (pst_reg == OTP_ST_LOW)
		&& i_program_strobe_n && low_ok;
	assign pulse_bad = prog_mode && (((pst_reg == OTP_ST_LOW)
		&& i_program_strobe_n && !low_ok) || ((pst_reg == OTP_ST_HIGH)
		&& !i_program_strobe_n && !gap_ok));
	assign commit = pulse_done
		&& (pulses_reg == 3'(OTP_PULSES - 1));

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			pst_reg    <= OTP_ST_WAIT;
			cnt_reg    <= '0;
			pulses_reg <= '0;
		end else if (i_clk_en) begin
			if (!prog_mode || pulse_bad) begin
				pst_reg    <= OTP_ST_WAIT;
				cnt_reg    <= '0;
				pulses_reg <= '0;
			end else begin
				unique case (pst_reg)
					OTP_ST_WAIT: begin
						if (i_program_strobe_n) begin
							pst_reg <= OTP_ST_HIGH;
						end
					end
					OTP_ST_LOW: begin
						if (i_program_strobe_n) begin
							pst_reg    <= OTP_ST_HIGH;
							cnt_reg    <= '0;
							pulses_reg <= commit ? 3'h0 : pulses_reg + 3'h1;
						end else if (cnt_reg != '1) begin
							cnt_reg <= cnt_reg + 1'b1;
						end
					end
					OTP_ST_HIGH: begin
						if (!i_program_strobe_n) begin
							pst_reg <= OTP_ST_LOW;
							cnt_reg <= OTP_CNT_W'(1);
						end else if (cnt_reg != '1) begin
							cnt_reg <= cnt_reg + 1'b1;
						end
					end
					default: begin
						pst_reg <= OTP_ST_WAIT;
					end
				endcase
			end
		end
	end

	// ==========================================================
	// Writes into the one-time storage; bits only go from one to zero.
	logic code_wr;
	logic key_wr;

	assign code_wr = commit && (sel == OTP_SEL_PROG_CODE) && !lvl1;
	assign key_wr  = commit && (sel == OTP_SEL_PROG_KEY) && !lvl1;

	always_ff @(posedge i_clock) begin
		if (i_clk_en && code_wr) begin
			code_mem[addr] <= code_mem[addr] & i_port0_in;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_clk_en && key_wr) begin
			key_mem[addr[5:0]] <= key_mem[addr[5:0]] & i_port0_in;
		end
	end

	// Lock bits stay programmable after any of them is set.
	always_ff @(posedge i_clock) begin
		if (i_clk_en && commit) begin
			lock1_reg <= lock1_reg | (sel == OTP_SEL_LOCK1);
			lock2_reg <= lock2_reg | (sel == OTP_SEL_LOCK2);
			lock3_reg <= lock3_reg | (sel == OTP_SEL_LOCK3);
		end
	end

	// ==========================================================
	// Verify and identification read-out on port 0.
	logic [7:0] rd_byte;
	logic       rd_drive;

	// The key array feeds only this XNOR, so it has no read path.
	always_comb begin
		rd_byte  = 8'hFF;
		rd_drive = 1'b0;
		if (sig_mode && (addr == OTP_SIG_ADDR0)) begin
			rd_byte  = SIG_BYTE0;
			rd_drive = 1'b1;
		end else if (sig_mode && (addr == OTP_SIG_ADDR1)) begin
			rd_byte  = SIG_BYTE1;
			rd_drive = 1'b1;
		end else if (verify_mode && !lvl2) begin
			rd_byte  = ~(code_mem[addr] ^ key_mem[addr[5:0]]);
			rd_drive = 1'b1;
		end
	end

	// Port 0 is open drain: only zero bits are driven.
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			o_port0_out <= 8'h00;
			o_port0_oe  <= 8'h00;
		end else if (i_clk_en) begin
			o_port0_out <= rd_drive ? rd_byte : 8'h00;
			o_port0_oe  <= rd_drive ? ~rd_byte : 8'h00;
		end
	end

	// ==========================================================
	// Run-time protection outputs and access pin latch.
	logic rst_seen_reg;
	logic ea_latch_reg;

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			rst_seen_reg <= 1'b0;
			ea_latch_reg <= 1'b0;
		end else if (i_clk_en && !rst_seen_reg) begin
			rst_seen_reg <= 1'b1;
			ea_latch_reg <= i_ext_access_level;
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			o_block_ext_code_read <= 1'b0;
			o_block_ext_exec      <= 1'b0;
			o_ext_access_eff      <= 1'b0;
		end else if (i_clk_en) begin
			o_block_ext_code_read <= lvl1;
			o_block_ext_exec      <= lvl3;
			o_ext_access_eff      <= lvl1 ? ea_latch_reg : i_ext_access_level;
		end
	end

	// ==========================================================
	// Software status: sticky strobe error and commit counter.
	logic        err_reg;
	logic [15:0] commits_reg;
	logic        wr_pend_reg;
	logic [3:0]  wr_addr_reg;
	logic        err_clr;

	assign err_clr = wr_pend_reg && (wr_addr_reg == OTP_REG_STATUS)
		&& i_hwdata[OTP_STAT_ERR_BIT];

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			err_reg <= 1'b0;
		end else if (i_clk_en) begin
			err_reg <= pulse_bad | (err_reg & ~err_clr);
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			commits_reg <= 16'h0000;
		end else if (i_clk_en && commit) begin
			commits_reg <= commits_reg + 16'h0001;
		end
	end

	// ==========================================================
	// AHB-Lite slave, zero wait states, always OKAY.
	logic [31:0] ctrl_reg;
	logic [31:0] status_word;
	logic [31:0] rd_word;
	logic        ahb_take;

	assign ctrl_en  = ctrl_reg[OTP_CTRL_EN_BIT];
	assign ahb_take = i_hsel && i_hready && (i_htrans == OTP_HTRANS_NONSEQ);
	assign status_word = {23'h0, prog_mode, pulses_reg, err_reg,
		ea_latch_reg, lock3_reg, lock2_reg, lock1_reg};

	always_comb begin
		unique case (i_haddr[3:0])
			OTP_REG_CTRL:   rd_word = ctrl_reg;
			OTP_REG_STATUS: rd_word = status_word;
			OTP_REG_COUNT:  rd_word = {16'h0000, commits_reg};
			default:        rd_word = 32'h0000_0000;
		endcase
		if (i_haddr[31:4] != 28'h0) begin
			rd_word = 32'h0000_0000;
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 4'h0;
			o_hrdata    <= 32'h0000_0000;
			o_hreadyout <= 1'b1;
			o_hresp     <= 1'b0;
		end else if (i_clk_en) begin
			o_hreadyout <= 1'b1;
			o_hresp     <= 1'b0;
			wr_pend_reg <= ahb_take && i_hwrite && (i_hsize == OTP_HSIZE_WORD)
				&& (i_haddr[31:4] == 28'h0);
			wr_addr_reg <= i_haddr[3:0];
			if (ahb_take && !i_hwrite) begin
				o_hrdata <= rd_word;
			end
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			ctrl_reg <= OTP_CTRL_RESET;
		end else if (i_clk_en && wr_pend_reg
			&& (wr_addr_reg == OTP_REG_CTRL)) begin
			ctrl_reg <= {31'h0, i_hwdata[OTP_CTRL_EN_BIT]};
		end
	end

	// ==========================================================
	// Checks.
	AST_FIVE_PULSES: assert property (i_clk_en && pulse_done
		&& !commit |=> pulses_reg == $past(pulses_reg) + 3'h1)
		else $error("Valid pulse not counted.");
	AST_LOCK_NO_WRITE: assert property (i_clk_en && lvl1 |=>
		code_mem[$past(addr)] == $past(code_mem[addr])
		&& key_mem[$past(addr[5:0])] == $past(key_mem[addr[5:0]]))
		else $error("Storage written while locked.");
	AST_VERIFY_REFUSED: assert property (i_clk_en && lvl2
		&& verify_mode |=> o_port0_oe == 8'h00)
		else $error("Verify answered while locked.");
	AST_VERIFY_XNOR: assert property (i_clk_en && verify_mode
		&& !lvl2 |=> o_port0_out == ~($past(code_mem[addr])
		^ $past(key_mem[addr[5:0]])))
		else $error("Verify byte is not the XNOR.");
	AST_SIG_BYTE: assert property (i_clk_en && sig_mode
		&& addr == OTP_SIG_ADDR1 |=> o_port0_oe == ~SIG_BYTE1)
		else $error("Second identification byte wrong.");
	AST_QUIET_PROG: assert property (i_clk_en && !read_mode
		|=> o_port0_oe == 8'h00)
		else $error("Port 0 driven outside read modes.");
	AST_CODE_READ_BLOCK: assert property (i_clk_en && lock1_reg
		|=> o_block_ext_code_read)
		else $error("Code reads not blocked.");
	AST_EXEC_BLOCK: assert property (i_clk_en && lock3_reg
		|=> o_block_ext_exec)
		else $error("External execution not blocked.");
	AST_SHORT_LOW: assert property (i_clk_en && prog_mode
		&& pst_reg == OTP_ST_LOW && i_program_strobe_n
		&& cnt_reg < OTP_CNT_W'(LOW_MIN_CYC)
		|=> err_reg && pulses_reg == 3'h0)
		else $error("Short pulse accepted.");

endmodule

`default_nettype wire

// *** sim/otp_prog_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Programming system on the far side of the pins.
module otp_prog_model #(
	parameter int LOW_CYC = 25
) (
	input  wire logic        i_clock,
	input  wire logic [7:0]  i_port0_oe,
	output logic             o_prog_reset,
	output logic             o_fetch_n,
	output logic             o_strobe_n,
	output logic             o_vpp,
	output logic      [3:0]  o_sel,
	output logic      [13:0] o_addr,
	output logic      [7:0]  o_data,
	output logic      [7:0]  o_pin
);
	// Pull-ups hold every undriven line of the open-drain port high.
	assign o_pin = ~i_port0_oe;

	initial begin
		o_prog_reset = 1'b1;
		o_fetch_n = 1'b0;
		o_strobe_n = 1'b1;
		o_vpp = 1'b0;
		o_sel = 4'h3;
		o_addr = 14'h0000;
		o_data = 8'hFF;
	end

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge i_clock);
	endtask

	task automatic read_loc(input logic [3:0] s, input logic [13:0] a,
		output logic [7:0] d);
		o_vpp <= 1'b0;
		o_strobe_n <= 1'b1;
		o_sel <= s;
		o_addr <= a;
		wait_cyc(4);
		d = o_pin;
	endtask

	// Five low pulses, each preceded by a 1260-cycle high gap, just above the minimum.
	task automatic prog_loc(input logic [3:0] s, input logic [13:0] a,
		input logic [7:0] d);
		o_sel <= s;
		o_addr <= a;
		o_data <= d;
		o_strobe_n <= 1'b1;
		o_vpp <= 1'b1;
		wait_cyc(1260);
		repeat (5) begin
			o_strobe_n <= 1'b0;
			wait_cyc(LOW_CYC);
			o_strobe_n <= 1'b1;
			wait_cyc(1260);
		end
		o_vpp <= 1'b0;
		wait_cyc(1);
	endtask

	// One low pulse far too short to be taken.
	task automatic short_pulse(input logic [3:0] s);
		o_sel <= s;
		o_strobe_n <= 1'b1;
		o_vpp <= 1'b1;
		wait_cyc(1260);
		o_strobe_n <= 1'b0;
		wait_cyc(LOW_CYC / 5);
		o_strobe_n <= 1'b1;
		wait_cyc(4);
		o_vpp <= 1'b0;
		wait_cyc(1);
	endtask
endmodule

`default_nettype wire

// *** sim/tb.sv ***
`timescale 1ns/1ps
`default_nettype none

module tb;
	import otp_pkg::*;
	logic        clock;
	logic        rst_n;
	logic        access;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic        prst;
	logic        fetch_n;
	logic        strobe_n;
	logic        vpp;
	logic [3:0]  sel;
	logic [13:0] addr;
	logic [7:0]  data;
	logic [7:0]  pin;
	logic [7:0]  p0_out;
	logic [7:0]  p0_oe;
	logic        blk_read;
	logic        blk_exec;
	logic        acc_eff;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	int          fails;
	int          cmp_count;

	otp_prog_model #(.LOW_CYC(25)) u_prog (
		.i_clock(clock), .i_port0_oe(p0_oe), .o_prog_reset(prst),
		.o_fetch_n(fetch_n), .o_strobe_n(strobe_n), .o_vpp(vpp),
		.o_sel(sel), .o_addr(addr), .o_data(data), .o_pin(pin));

	otp_prog_verify #(.LOW_MIN_CYC(20), .LOW_MAX_CYC(30)) u_dut (
		.i_clock(clock), .i_rst_n(rst_n), .i_clk_en(1'b1),
		.i_prog_reset(prst), .i_code_fetch_strobe_n(fetch_n),
		.i_program_strobe_n(strobe_n), .i_ext_access_level(access),
		.i_ext_access_prog_voltage(vpp), .i_mode_sel_a(sel[3]),
		.i_mode_sel_b(sel[2]), .i_mode_sel_c(sel[1]),
		.i_mode_sel_d(sel[0]), .i_addr_low(addr[7:0]),
		.i_addr_high(addr[13:8]), .i_port0_in(data),
		.o_port0_out(p0_out), .o_port0_oe(p0_oe),
		.o_block_ext_code_read(blk_read), .o_block_ext_exec(blk_exec),
		.o_ext_access_eff(acc_eff), .i_hsel(hsel), .i_haddr(haddr),
		.i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
		.i_hwdata(hwdata), .i_hready(hreadyout), .o_hrdata(hrdata),
		.o_hreadyout(hreadyout), .o_hresp(hresp));

	// The oscillator runs through the whole programming session.
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	task automatic stop_test;
		$display("checks %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic ahb(input logic w, input logic [3:0] a,
		input logic [31:0] wd, output logic [31:0] rd);
		hsel <= 1'b1;
		haddr <= {28'h0000000, a};
		htrans <= OTP_HTRANS_NONSEQ;
		hwrite <= w;
		hsize <= OTP_HSIZE_WORD;
		do @(posedge clock); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= wd;
		do @(posedge clock); while (hreadyout !== 1'b1);
		rd = hrdata;
		chk("hresp", 32'h0, {31'h0, hresp});
	endtask

	task automatic vchk(input string n, input logic [3:0] s,
		input logic [13:0] a, input logic [7:0] e);
		logic [7:0] d;
		u_prog.read_loc(s, a, d);
		chk(n, {24'h0, e}, {24'h0, d});
	endtask

	task automatic t_regs;
		logic [31:0] r;
		ahb(1'b0, OTP_REG_CTRL, 32'h0, r);
		chk("ctrl", OTP_CTRL_RESET, r);
		ahb(1'b0, OTP_REG_STATUS, 32'h0, r);
		chk("locks clear", 32'h0, r & 32'h7);
		ahb(1'b1, 4'hC, 32'hFFFF_FFFF, r);
		ahb(1'b0, 4'hC, 32'h0, r);
		chk("unmapped", 32'h0, r);
	endtask

	task automatic t_reads;
		vchk("blank", OTP_SEL_VERIFY, 14'h0141, 8'hFF);
		vchk("sig0", OTP_SEL_SIG, OTP_SIG_ADDR0, 8'hA5);
		vchk("sig1", OTP_SEL_SIG, OTP_SIG_ADDR1, 8'h5A);
		chk("out sig1", 32'h5A, {24'h0, p0_out});
	endtask

	task automatic t_err;
		logic [31:0] r;
		u_prog.short_pulse(OTP_SEL_PROG_CODE);
		ahb(1'b0, OTP_REG_STATUS, 32'h0, r);
		chk("err set", 32'h10, r & 32'h1F0);
		ahb(1'b1, OTP_REG_STATUS, 32'h10, r);
		ahb(1'b0, OTP_REG_STATUS, 32'h0, r);
		chk("err clr", 32'h0, r & 32'h10);
		ahb(1'b1, OTP_REG_CTRL, 32'h0, r);
		u_prog.short_pulse(OTP_SEL_PROG_CODE);
		ahb(1'b0, OTP_REG_STATUS, 32'h0, r);
		chk("err off", 32'h0, r & 32'h10);
		ahb(1'b1, OTP_REG_CTRL, 32'h1, r);
		ahb(1'b0, OTP_REG_COUNT, 32'h0, r);
		chk("count none", 32'h0, r & 32'hFFFF);
	endtask

	task automatic t_code_key;
		logic [31:0] r;
		u_prog.prog_loc(OTP_SEL_PROG_CODE, 14'h0141, 8'h3C);
		vchk("code", OTP_SEL_VERIFY, 14'h0141, 8'h3C);
		chk("out code", 32'h3C, {24'h0, p0_out});
		u_prog.prog_loc(OTP_SEL_PROG_KEY, 14'h0001, 8'h0F);
		vchk("enc", OTP_SEL_VERIFY, 14'h0141, 8'hCC);
		vchk("enc hi", OTP_SEL_VERIFY, 14'h3FC1, 8'h0F);
		vchk("no key read", OTP_SEL_SIG, 14'h0001, 8'hFF);
		ahb(1'b0, OTP_REG_COUNT, 32'h0, r);
		chk("count", 32'h2, r & 32'hFFFF);
	endtask

	task automatic t_locks;
		logic [31:0] r;
		u_prog.prog_loc(OTP_SEL_LOCK1, 14'h0000, 8'h00);
		chk("blk read", 32'h1, {31'h0, blk_read});
		access <= 1'b0;
		u_prog.wait_cyc(4);
		chk("acc latched", 32'h1, {31'h0, acc_eff});
		access <= 1'b1;
		u_prog.prog_loc(OTP_SEL_PROG_CODE, 14'h0141, 8'h00);
		u_prog.prog_loc(OTP_SEL_PROG_KEY, 14'h0001, 8'h00);
		vchk("locked", OTP_SEL_VERIFY, 14'h0141, 8'hCC);
		ahb(1'b0, OTP_REG_COUNT, 32'h0, r);
		chk("count lk", 32'h5, r & 32'hFFFF);
		u_prog.prog_loc(OTP_SEL_LOCK2, 14'h0000, 8'h00);
		vchk("refused", OTP_SEL_VERIFY, 14'h0141, 8'hFF);
		chk("out refused", 32'h0, {24'h0, p0_out});
		vchk("sig lk", OTP_SEL_SIG, OTP_SIG_ADDR0, 8'hA5);
		chk("exec open", 32'h0, {31'h0, blk_exec});
		u_prog.prog_loc(OTP_SEL_LOCK3, 14'h0000, 8'h00);
		chk("exec blk", 32'h1, {31'h0, blk_exec});
		ahb(1'b0, OTP_REG_STATUS, 32'h0, r);
		chk("locks set", 32'h7, r & 32'h7);
	endtask

	initial begin
		fails = 0;
		cmp_count = 0;
		rst_n = 1'b0;
		access = 1'b1;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = OTP_HSIZE_WORD;
		hwdata = 32'h0;
		repeat (16) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		t_regs();
		t_reads();
		t_err();
		t_code_key();
		t_locks();
		stop_test();
	end

	// Seven programmed locations and two short pulses take about 57000 cycles.
	initial begin
		#600000;
		fails++;
		$display("MISMATCH watchdog expected done seen hang");
		stop_test();
	end
endmodule

`default_nettype wire
